// file: bccr_pkg.sv
package bccr_pkg;
    localparam logic [7:0]  BCCR_CTRL_ADDR   = 8'hc0;
    localparam logic [7:0]  BCCR_SEQ_ADDR    = 8'hc1;
    localparam logic [7:0]  BCCR_IRQ_STS_ADDR = 8'hc8;
    localparam logic [7:0]  BCCR_IRQ_MSK_ADDR = 8'hc9;
    localparam logic [7:0]  BCCR_STATE_ADDR  = 8'hca;

    // control register field positions
    localparam int BCCR_TOPO_BIT   = 14;
    localparam int BCCR_SLEEP_BIT  = 12;
    localparam int BCCR_SRC_LSB    = 8;
    localparam int BCCR_ILIM_BIT   = 6;
    localparam int BCCR_RMPH_BIT   = 4;
    localparam int BCCR_RMPL_BIT   = 3;
    localparam int BCCR_FB_LSB     = 0;
    // sequencing register field positions
    localparam int BCCR_ACT_LSB    = 14;
    localparam int BCCR_EN_LSB     = 10;
    localparam int BCCR_SD_LSB     = 6;

    localparam logic [15:0] BCCR_CTRL_MASK  = 16'h535b;
    localparam logic [15:0] BCCR_SEQ_MASK   = 16'hffc0;
    localparam logic [15:0] BCCR_CTRL_RESET = 16'h0008;
    localparam logic [15:0] BCCR_SEQ_RESET  = 16'h0000;

    localparam logic [1:0] BCCR_FB_USB      = 2'h3;
    localparam logic [1:0] BCCR_RAMP_LOWEST = 2'h3;
    localparam logic [3:0] BCCR_SLOT_OFF    = 4'h0;
    localparam logic [3:0] BCCR_SLOT_EDGE   = 4'hf;

    // irq status bits
    localparam int BCCR_IRQ_FAULT = 0;
    localparam int BCCR_IRQ_SLEEP = 1;

    typedef enum logic [1:0] {
        BCCR_ACT_IGNORE   = 2'b00,
        BCCR_ACT_CONV_OFF = 2'b01,
        BCCR_ACT_SYS_OFF  = 2'b10,
        BCCR_ACT_RSVD     = 2'b11
    } bccr_action_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bccr_bus_s;

    typedef struct packed {
        logic       topology;
        logic       sleep_off;
        logic       ilim_low;
        logic [1:0] ramp;
        logic [1:0] feedback;
        logic [3:0] startup_slot;
        logic [3:0] shutdown_slot;
        logic       start_on_active;
        logic       stop_on_off;
    } bccr_cfg_s;
endpackage : bccr_pkg

// file: bccr_fault_act.sv
`timescale 1ns/1ns
module bccr_fault_act
    import bccr_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       fault_i,
    input  wire logic [1:0] action_i,
    input  wire logic       clear_i,
    output logic            conv_shutdown_o,
    output logic            sys_shutdown_o
);
    logic conv_q;
    logic sys_q;

    // latched until the sequencer clears; a fresh fault beats the clear
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_q <= 1'b0;
            sys_q  <= 1'b0;
        end else begin
            if (clear_i) begin
                conv_q <= 1'b0;
                sys_q  <= 1'b0;
            end
            // set comes last so only the latch being set survives a clear
            if (fault_i) begin
                unique case (bccr_action_e'(action_i))
                    BCCR_ACT_IGNORE: begin
                    end
                    BCCR_ACT_CONV_OFF: begin
                        conv_q <= 1'b1;
                    end
                    BCCR_ACT_SYS_OFF, BCCR_ACT_RSVD: begin
                        sys_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign conv_shutdown_o = conv_q;
    assign sys_shutdown_o  = sys_q;
endmodule : bccr_fault_act

// file: bccr_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/1ns
// Operation
// - sleep behaviour bit: clear keeps running, set disables output in sleep
// - sleep source field picks register bit or one of three low-power inputs
// - asserted general-purpose sleep pin forces sleep regardless of source field
// - current limit bit: 0 higher peak current, 1 lower peak current
// - two ramp bits, high then low, select the compensation range
// - feedback source 11 forces ramp code 11
// - feedback source field routes external pin, sink one, sink two, usb divider
// - every converter fault sets the fault status bit, whatever the action; irq_o rises only if its mask bit is set
// - fault action: 00 ignore, 01 converter off, 10 system off
// - reserved fault action 11 behaves as system off
// - start-up slot: 0 off, 1..14 slots, 15 on entering active
// - shutdown slot: 1..14 slots, 0 and 15 on entering off
// - state machine restores control and sequencing fields to fixed reset defaults; irq mask and status keep their values
module bccr_regs
    import bccr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        sm_restore_i,
    input  wire logic        sleep_reg_bit_i,
    input  wire logic        low_power_input_one_i,
    input  wire logic        low_power_input_two_i,
    input  wire logic        low_power_input_three_i,
    input  wire logic        gpio_sleep_i,
    input  wire logic        conv_fault_i,
    input  wire logic        fault_clear_i,
    output logic             conv_enable_o,
    output logic             in_sleep_o,
    output logic             conv_topology_select_o,
    output logic             peak_current_low_o,
    output logic      [1:0]  comp_ramp_o,
    output logic      [3:0]  feedback_route_o,
    output logic      [3:0]  startup_slot_select_o,
    output logic      [3:0]  shutdown_slot_select_o,
    output logic             start_on_active_o,
    output logic             stop_on_off_o,
    output logic             conv_shutdown_o,
    output logic             sys_shutdown_o,
    output logic             irq_o
);
    logic        rst_s1_q;
    logic        rst_n;
    logic [15:0] ctrl_q;
    logic [15:0] seq_q;
    logic [1:0]  irq_sts_q;
    logic [1:0]  irq_msk_q;
    logic [15:0] rdata_q;
    logic        sleep_q;
    logic        sleep_d;
    logic        sleep_src;
    logic [1:0]  ramp_d;
    logic [1:0]  fb_src;
    logic        conv_off;
    bccr_cfg_s   cfg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = (a == base);
    endfunction : hit

    // two-flop release so no register leaves reset on a marginal edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= BCCR_CTRL_RESET;
        end else if (sm_restore_i) begin
            ctrl_q <= BCCR_CTRL_RESET;
        end else if (reg_wr_i && hit(reg_addr_i, BCCR_CTRL_ADDR)) begin
            ctrl_q <= reg_wdata_i & BCCR_CTRL_MASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_q <= BCCR_SEQ_RESET;
        end else if (sm_restore_i) begin
            seq_q <= BCCR_SEQ_RESET;
        end else if (reg_wr_i && hit(reg_addr_i, BCCR_SEQ_ADDR)) begin
            seq_q <= reg_wdata_i & BCCR_SEQ_MASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_msk_q <= 2'h0;
        end else if (reg_wr_i && hit(reg_addr_i, BCCR_IRQ_MSK_ADDR)) begin
            irq_msk_q <= reg_wdata_i[1:0];
        end
    end

    // sleep selection
    assign fb_src = ctrl_q[BCCR_FB_LSB +: 2];

    always_comb begin
        unique case (ctrl_q[BCCR_SRC_LSB +: 2])
            2'h0: sleep_src = sleep_reg_bit_i;
            2'h1: sleep_src = low_power_input_one_i;
            2'h2: sleep_src = low_power_input_two_i;
            2'h3: sleep_src = low_power_input_three_i;
        endcase
        sleep_d = sleep_src | gpio_sleep_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_d;
        end
    end

    always_comb begin
        if (fb_src == BCCR_FB_USB) begin
            ramp_d = BCCR_RAMP_LOWEST;
        end else begin
            ramp_d = {ctrl_q[BCCR_RMPH_BIT], ctrl_q[BCCR_RMPL_BIT]};
        end
    end

    // sticky status: event set wins over the read-clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_sts_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == BCCR_IRQ_FAULT && conv_fault_i) ||
                    (i == BCCR_IRQ_SLEEP && sleep_d && !sleep_q)) begin
                    irq_sts_q[i] <= 1'b1;
                end else if (reg_rd_i && hit(reg_addr_i, BCCR_IRQ_STS_ADDR)) begin
                    irq_sts_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, BCCR_CTRL_ADDR)) begin
                rdata_q <= ctrl_q;
            end else if (hit(reg_addr_i, BCCR_SEQ_ADDR)) begin
                rdata_q <= seq_q;
            end else if (hit(reg_addr_i, BCCR_IRQ_STS_ADDR)) begin
                rdata_q <= {14'h0000, irq_sts_q};
            end else if (hit(reg_addr_i, BCCR_IRQ_MSK_ADDR)) begin
                rdata_q <= {14'h0000, irq_msk_q};
            end else if (hit(reg_addr_i, BCCR_STATE_ADDR)) begin
                rdata_q <= {12'h000, sys_shutdown_o, conv_shutdown_o, conv_enable_o, sleep_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    bccr_fault_act u_fault (
        .core_clk_i      (core_clk_i),
        .rst_n_i         (rst_n),
        .fault_i         (conv_fault_i),
        .action_i        (seq_q[BCCR_ACT_LSB +: 2]),
        .clear_i         (fault_clear_i | sm_restore_i),
        .conv_shutdown_o (conv_shutdown_o),
        .sys_shutdown_o  (sys_shutdown_o)
    );

    always_comb begin
        cfg                 = '0;
        cfg.topology        = ctrl_q[BCCR_TOPO_BIT];
        cfg.sleep_off       = ctrl_q[BCCR_SLEEP_BIT];
        cfg.ilim_low        = ctrl_q[BCCR_ILIM_BIT];
        cfg.ramp            = ramp_d;
        cfg.feedback        = fb_src;
        cfg.startup_slot    = seq_q[BCCR_EN_LSB +: 4];
        cfg.shutdown_slot   = seq_q[BCCR_SD_LSB +: 4];
        cfg.start_on_active = (cfg.startup_slot == BCCR_SLOT_EDGE);
        cfg.stop_on_off     = (cfg.shutdown_slot == BCCR_SLOT_OFF) ||
                              (cfg.shutdown_slot == BCCR_SLOT_EDGE);
    end

    assign conv_off = (sleep_q && cfg.sleep_off) || conv_shutdown_o || sys_shutdown_o;

    // feedback route as one-hot: pin, sink one, sink two, usb divider
    assign feedback_route_o = 4'h1 << cfg.feedback;

    assign reg_rdata_o            = rdata_q;
    assign in_sleep_o             = sleep_q;
    assign conv_enable_o          = (cfg.startup_slot != BCCR_SLOT_OFF) && !conv_off;
    assign conv_topology_select_o = cfg.topology;
    assign peak_current_low_o     = cfg.ilim_low;
    assign comp_ramp_o            = cfg.ramp;
    assign startup_slot_select_o  = cfg.startup_slot;
    assign shutdown_slot_select_o = cfg.shutdown_slot;
    assign start_on_active_o      = cfg.start_on_active;
    assign stop_on_off_o          = cfg.stop_on_off;
    assign irq_o                  = |(irq_sts_q & irq_msk_q);
endmodule : bccr_regs

// file: bccr_chk_sva.sv
`timescale 1ns/1ns
module bccr_chk
    import bccr_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        sm_restore_i,
    input wire logic        gpio_sleep_i,
    input wire logic        in_sleep_o,
    input wire logic        peak_current_low_o,
    input wire logic [1:0]  comp_ramp_o,
    input wire logic [3:0]  feedback_route_o,
    input wire logic [3:0]  startup_slot_select_o,
    input wire logic [3:0]  shutdown_slot_select_o,
    input wire logic        start_on_active_o,
    input wire logic        stop_on_off_o
);
    logic [2:0] rs_q;
    // design holds its own copy in reset two edges longer
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) rs_q <= 3'h0;
        else rs_q <= {rs_q[1:0], 1'b1};
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_cw;
        rs_q[2] && reg_wr_i && reg_addr_i == 8'hc0 && !sm_restore_i;
    endsequence
    property p_ramp_force;
        feedback_route_o == 4'h8 |-> comp_ramp_o == 2'h3;
    endproperty
    a_ramp_force: assert property (p_ramp_force) else $error("ramp not forced");
    property p_start_act;
        start_on_active_o == (startup_slot_select_o == 4'hf);
    endproperty
    a_start_act: assert property (p_start_act) else $error("start on active");
    property p_stop_off;
        stop_on_off_o == (shutdown_slot_select_o inside {4'h0, 4'hf});
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop on off");
    property p_ctrl_wr;
        s_cw and reg_wdata_i[1:0] != 2'h3 |=> {peak_current_low_o, comp_ramp_o} == $past({reg_wdata_i[6], reg_wdata_i[4:3]});
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write");
    property p_fb_wr;
        s_cw |=> feedback_route_o == 4'h1 << $past(reg_wdata_i[1:0]);
    endproperty
    a_fb_wr: assert property (p_fb_wr) else $error("feedback route");
    property p_seq_wr;
        rs_q[2] && reg_wr_i && reg_addr_i == 8'hc1 && !sm_restore_i
            |=> {startup_slot_select_o, shutdown_slot_select_o} == $past(reg_wdata_i[13:6]);
    endproperty
    a_seq_wr: assert property (p_seq_wr) else $error("seq write");
    property p_restore;
        rs_q[2] && sm_restore_i |=> comp_ramp_o == 2'h1 && startup_slot_select_o == 4'h0 && !peak_current_low_o;
    endproperty
    a_restore: assert property (p_restore) else $error("restore");
    property p_gpio;
        rs_q[2] && gpio_sleep_i |=> in_sleep_o;
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio sleep");
    c_cw: cover property (s_cw);
    c_restore: cover property (rs_q[2] && sm_restore_i);
    c_gpio: cover property (gpio_sleep_i ##1 in_sleep_o);
endmodule : bccr_chk

bind bccr_regs bccr_chk i_chk (.*);

// file: tb.sv
`timescale 1ns/1ns
module tb;
    import bccr_pkg::*;
    logic        clk, nrst, wr, rd, rst_sm, gpio, fault, fclr, en, slp, csd, ssd, irq, topo;
    logic [7:0]  addr;
    logic [15:0] wd, rdata, v;
    logic [3:0]  hib, route;
    logic [1:0]  ramp;
    int          n_fail = 0, total_checks = 0, cyc = 0;
    bccr_regs i_dut (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sm_restore_i(rst_sm),
        .sleep_reg_bit_i(hib[0]), .low_power_input_one_i(hib[1]), .low_power_input_two_i(hib[2]),
        .low_power_input_three_i(hib[3]), .gpio_sleep_i(gpio), .conv_fault_i(fault),
        .fault_clear_i(fclr), .conv_enable_o(en), .in_sleep_o(slp), .conv_topology_select_o(topo),
        .peak_current_low_o(), .comp_ramp_o(ramp), .feedback_route_o(route),
        .startup_slot_select_o(), .shutdown_slot_select_o(), .start_on_active_o(),
        .stop_on_off_o(), .conv_shutdown_o(csd), .sys_shutdown_o(ssd), .irq_o(irq));
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    task automatic rdt(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rdt
    task automatic pulse_fault();
        fault <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse_fault
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {nrst, wr, rd, rst_sm, gpio, fault, fclr} = '0;
        addr = 8'h00;
        wd = 16'h0000;
        hib = 4'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdt(8'hc0);
        chk("ctrl", 16'h0008, v);
        wrt(8'hc0, 16'hffff);
        rdt(8'hc0);
        chk("ctrl", 16'h535b, v);
        chk("topology", 16'h1, 16'(topo));
        wrt(8'hc1, 16'hffff);
        rdt(8'hc1);
        chk("seq", 16'hffc0, v);
        for (int i = 0; i < 4; i++) begin
            wrt(8'hc0, 16'h0040 | 16'((3 - i) << 3 | i));
            #1 chk("ramp", (i == 3) ? 16'h3 : 16'(3 - i), 16'(ramp));
            chk("route", 16'h1 << i, 16'(route));
        end
        @(posedge clk);
        rst_sm <= 1'b1;
        @(posedge clk);
        rst_sm <= 1'b0;
        rdt(8'hc1);
        chk("seq", 16'h0000, v);
        wrt(8'hc1, 16'h0400);
        for (int s = 0; s < 4; s++) begin
            wrt(8'hc0, 16'h1000 | 16'(s << 8));
            hib <= 4'h1 << s;
            repeat (2) @(posedge clk);
            #1 chk("sleep", 16'h1, 16'(slp));
            chk("enable", 16'h0, 16'(en));
            @(posedge clk);
            hib <= ~(4'h1 << s);
            repeat (2) @(posedge clk);
            #1 chk("sleep", 16'h0, 16'(slp));
            chk("enable", 16'h1, 16'(en));
        end
        wrt(8'hc0, 16'h0000);
        hib <= 4'h0;
        gpio <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("sleep", 16'h1, 16'(slp));
        chk("enable", 16'h1, 16'(en));
        @(posedge clk);
        gpio <= 1'b0;
        rdt(8'hc8);
        chk("status", 16'h0002, v);
        wrt(8'hc9, 16'h0001);
        for (int a = 0; a < 4; a++) begin
            wrt(8'hc1, 16'(a << 14) | 16'h0400);
            pulse_fault();
            chk("conv_sd", 16'(a == 1), 16'(csd));
            chk("sys_sd", 16'(a >= 2), 16'(ssd));
            chk("irq", 16'h1, 16'(irq));
            rdt(8'hca);
            chk("state", (a == 0) ? 16'h0002 : (a == 1) ? 16'h0004 : 16'h0008, v);
            rdt(8'hc8);
            chk("status", 16'h0001, v);
            chk("irq", 16'h0, 16'(irq));
            @(posedge clk);
            fclr <= 1'b1;
            @(posedge clk);
            fclr <= 1'b0;
        end
        wrt(8'hc9, 16'h0000);
        pulse_fault();
        chk("irq", 16'h0, 16'(irq));
        rdt(8'hc8);
        chk("status", 16'h0001, v);
        conclude();
    end
endmodule : tb
